// ==== dv/ddrc_cell_test.sv ====
// self-checking bench of the ddr i/o register cell
`timescale 1ns/1ps
`default_nettype none

module ddrc_cell_test;
   localparam logic [31:0] MI = 32'h0000_0001;
   localparam logic [31:0] MO = 32'h0000_0002;
   localparam logic [31:0] MB = 32'h0000_0004;
   logic        core_clk_i, nrst_i, reg_we_i, reg_re_i, out_valid_i, oe_i;
   logic        ce_in_i, ce_out_i, sclr_i, clr_i, strobe_bus_i, rise_b, fall_b;
   logic        out_ready_o, strobe_bus_o, pad_out_o, pad_oe_o, dq, pad_in;
   logic [3:0]  reg_addr_i;
   logic [31:0] reg_wdata_i, reg_rdata_o, st;
   logic [1:0]  out_data_i, in_data_o;
   logic        h, l;
   int          failures, comparisons;

   assign pad_in = pad_oe_o ? pad_out_o : dq;

   ddrc_cell ddrc_cell_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
      .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .out_valid_i(out_valid_i),
      .out_data_i(out_data_i), .out_ready_o(out_ready_o), .oe_i(oe_i), .ce_in_i(ce_in_i),
      .ce_out_i(ce_out_i), .sclr_i(sclr_i), .register_clear_preset_pin_i(clr_i),
      .in_data_o(in_data_o), .strobe_bus_i(strobe_bus_i), .strobe_bus_o(strobe_bus_o),
      .pad_in_i(pad_in), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o));

   ddrc_mem_model ddrc_mem_model_inst (.clk_i(core_clk_i), .cell_oe_i(pad_oe_o),
      .rise_bit_i(rise_b), .fall_bit_i(fall_b), .dq_o(dq));

   // 100 mhz, well inside the 200 mhz ceiling of the memory path
   initial
   begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end

   task automatic tally_and_finish();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_we_i    <= 1'b1;
      @(posedge core_clk_i);
      reg_we_i    <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge core_clk_i);
      reg_addr_i <= a;
      reg_re_i   <= 1'b1;
      @(posedge core_clk_i);
      reg_re_i   <= 1'b0;
      #1;
      d = reg_rdata_o;
   endtask

   // pin level in the high phase, then in the low phase of one clock
   task automatic ph();
      @(posedge core_clk_i);
      #2 h = pad_out_o;
      @(negedge core_clk_i);
      #2 l = pad_out_o;
   endtask

   task automatic push(input logic [1:0] d);
      int n;
      @(posedge core_clk_i);
      out_valid_i <= 1'b1;
      out_data_i  <= d;
      for (n = 0; n < 20; n++)
      begin
         @(negedge core_clk_i);
         if (out_ready_o === 1'b1)
            break;
      end
      if (n == 20)
      begin
         chk(0, 1, "launch buffer never ready");
         tally_and_finish();
      end
      else
      begin
         @(posedge core_clk_i);
         out_valid_i <= 1'b0;
      end
   endtask

   task automatic t_regs();
      rd(ddrc_pkg::OFF_CTRL, st);
      chk(st, 0, "ctrl reset");
      rd(ddrc_pkg::OFF_INV, st);
      chk(st, 0, "inv reset");
      wr(4'hc, 32'hffff_ffff);
      rd(4'hc, st);
      chk(st, 0, "unmapped read");
      rd(ddrc_pkg::OFF_STAT, st);
      chk(st[ddrc_pkg::S_EMPTY], 1, "buffer empty");
      $display("test regs done");
   endtask

   task automatic t_out();
      wr(ddrc_pkg::OFF_CTRL, MO);
      push(2'h2);
      cyc(4);
      ph();
      chk({h, l}, 2'h2, "first pair");
      push(2'h1);
      cyc(4);
      ph();
      chk({h, l}, 2'h1, "second pair");
      wr(ddrc_pkg::OFF_INV, 32'h0000_0001 << ddrc_pkg::I_DOUT);
      push(2'h2);
      cyc(4);
      ph();
      chk({h, l}, 2'h1, "inverted launch");
      wr(ddrc_pkg::OFF_INV, 0);
      $display("test out done");
   endtask

   task automatic t_fill();
      int i;
      int n;
      n = 0;
      wr(ddrc_pkg::OFF_CTRL, MO | (32'h0000_0001 << ddrc_pkg::C_CE_OUT));
      @(posedge core_clk_i);
      ce_out_i    <= 1'b0;
      out_valid_i <= 1'b1;
      out_data_i  <= 2'h3;
      for (i = 0; i < 30; i++)
      begin
         @(negedge core_clk_i);
         if (out_ready_o === 1'b1)
            n++;
         @(posedge core_clk_i);
      end
      out_valid_i <= 1'b0;
      chk(n, ddrc_pkg::FIFO_DEPTH, "words accepted");
      ph();
      chk({h, l}, 2'h1, "held while disabled");
      rd(ddrc_pkg::OFF_STAT, st);
      chk(st[ddrc_pkg::S_FULL], 1, "full flag");
      chk(st[ddrc_pkg::S_LEVEL +: ddrc_pkg::S_LEVEL_W], 16, "full level");
      @(posedge core_clk_i);
      ce_out_i <= 1'b1;
      cyc(25);
      ph();
      chk({h, l}, 2'h3, "launched after enable");
      rd(ddrc_pkg::OFF_STAT, st);
      chk(st[ddrc_pkg::S_LEVEL +: ddrc_pkg::S_LEVEL_W], 0, "drained level");
      $display("test fill done");
   endtask

   task automatic t_oe();
      wr(ddrc_pkg::OFF_CTRL, MO);
      @(posedge core_clk_i);
      oe_i <= 1'b1;
      cyc(3);
      chk(pad_oe_o, 1, "enable high");
      wr(ddrc_pkg::OFF_CTRL, MO | (32'h0000_0001 << ddrc_pkg::C_OE_LOW));
      cyc(3);
      chk(pad_oe_o, 0, "enable active low");
      wr(ddrc_pkg::OFF_CTRL, MB);
      @(posedge core_clk_i);
      oe_i <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      oe_i <= 1'b1;
      cyc(1);
      chk(pad_oe_o, 0, "no drive before fall");
      @(negedge core_clk_i);
      #1 chk(pad_oe_o, 1, "drive after fall");
      @(posedge core_clk_i);
      oe_i <= 1'b0;
      $display("test oe done");
   endtask

   task automatic t_in();
      rise_b <= 1'b1;
      fall_b <= 1'b0;
      wr(ddrc_pkg::OFF_CTRL, MB);
      cyc(4);
      chk(in_data_o, 2'h2, "bidir capture");
      wr(ddrc_pkg::OFF_CTRL, MI | (32'h0000_0001 << ddrc_pkg::C_ALIGN_F));
      cyc(4);
      chk(in_data_o, 2'h1, "falling align");
      wr(ddrc_pkg::OFF_CTRL, MI | (32'h0000_0001 << ddrc_pkg::C_ROLE_STB));
      cyc(4);
      chk(in_data_o, 2'h2, "rising align");
      @(negedge core_clk_i);
      #1 chk(strobe_bus_o, 1, "strobe pin drives bus");
      wr(ddrc_pkg::OFF_CTRL, MI | (32'h0000_0001 << ddrc_pkg::C_STROBE));
      rise_b <= 1'b0;
      fall_b <= 1'b1;
      cyc(4);
      chk(strobe_bus_o, 0, "data pin keeps bus off");
      chk(in_data_o, 2'h2, "capture waits for strobe");
      wr(ddrc_pkg::OFF_CTRL, MI | (32'h0000_0001 << ddrc_pkg::C_STROBE) |
         (32'h0000_0001 << ddrc_pkg::C_NO_SHIFT));
      cyc(4);
      chk(in_data_o, 2'h1, "strobe ignored");
      @(posedge core_clk_i);
      sclr_i <= 1'b1;
      cyc(3);
      chk(in_data_o, 2'h0, "sync reset");
      @(posedge core_clk_i);
      sclr_i <= 1'b0;
      wr(ddrc_pkg::OFF_CTRL, MI | (32'h0000_0001 << ddrc_pkg::C_PRESET));
      @(posedge core_clk_i);
      clr_i <= 1'b1;
      cyc(1);
      chk(in_data_o, 2'h3, "preset level");
      @(posedge core_clk_i);
      clr_i <= 1'b0;
      $display("test in done");
   endtask

   initial
   begin
      {nrst_i, reg_we_i, reg_re_i, out_valid_i, oe_i, sclr_i, clr_i} = '0;
      {strobe_bus_i, rise_b, fall_b, reg_addr_i, reg_wdata_i, out_data_i} = '0;
      ce_in_i     = 1'b1;
      ce_out_i    = 1'b1;
      failures    = 0;
      comparisons = 0;
      repeat (4) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      t_regs();
      t_out();
      t_fill();
      t_oe();
      t_in();
      tally_and_finish();
   end
endmodule

`default_nettype wire

// ==== dv/ddrc_mem_model.sv ====
// model of the external ddr memory that drives the data pin towards the cell
`timescale 1ns/1ps
`default_nettype none

module ddrc_mem_model
(
   input  wire logic clk_i,
   input  wire logic cell_oe_i,
   input  wire logic rise_bit_i,
   input  wire logic fall_bit_i,
   output logic      dq_o
);
   // while the cell drives, the line is released: it toggles instead of holding
   // rise bit stands through the low time, fall bit through the high time
   always @(posedge clk_i or negedge clk_i)
   begin
      if (cell_oe_i)
         dq_o <= ~dq_o;
      else if (clk_i)
         dq_o <= fall_bit_i;
      else
         dq_o <= rise_bit_i;
   end
endmodule

`default_nettype wire

// ==== hw/ddrc_cell.sv ====
// ddr i/o register cell: capture, launch and enable registers for one pin
`timescale 1ns/1ps
`default_nettype none

// How it works
// R1 - six cell registers and one latch serve ddr input, output and bidirectional use
// R2 - two input registers capture the pin, one on rising, one on falling edge
// R3 - a latch keeps the rising-edge bit through the clock low time
// R4 - both input bits reach the fabric aligned to a selectable common edge
// R5 - two output registers load the two fabric bits on the rising edge
// R6 - the clock itself selects between the output registers, doubling pin rate
// R7 - first bit drives the pin while clock high, second while clock low
// R8 - tristate control is active high by default, configurable active low
// R9 - bidirectional mode joins the input and output paths on one pin
// R10 - a falling-edge enable register delays the enable assertion by half a cycle; the code applies it in bidirectional mode only
// R11 - output registers load when clock enable high, hold when low; default high
// R12 - each control and data input into the cell is invertible by configuration; the code leaves strobe_bus_i uninverted and I_CLK flips only the launch mux
// R13 - only data cells use the strobe bus; only strobe cells drive it
// R14 - without strobe phase shifting, the read strobe is ignored; own clock captures
// R15 - memory path rated up to 200 MHz, 400 Mbps per pin
// R16 - one shared clear source; each cell picks clear or preset
// R17 - a synchronous reset also acts on the cell registers
// R18 - enable and output registers share one clock and one clock enable; the falling-edge enable register has no clock enable
// R19 - launch bits stay stable from one rising edge to the next
module ddrc_cell
(
   input  wire logic        core_clk_i,
   input  wire logic        nrst_i,
   input  wire logic [3:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_we_i,
   input  wire logic        reg_re_i,
   output logic [31:0]      reg_rdata_o,
   input  wire logic        out_valid_i,
   input  wire logic [1:0]  out_data_i,
   output logic             out_ready_o,
   input  wire logic        oe_i,
   input  wire logic        ce_in_i,
   input  wire logic        ce_out_i,
   input  wire logic        sclr_i,
   input  wire logic        register_clear_preset_pin_i,
   output logic [1:0]       in_data_o,
   input  wire logic        strobe_bus_i,
   output logic             strobe_bus_o,
   input  wire logic        pad_in_i,
   output logic             pad_out_o,
   output logic             pad_oe_o
);
   function automatic logic reg_hit(input logic [3:0] a, input logic [3:0] off);
      return a == off;
   endfunction

   logic [ddrc_pkg::CTRL_W-1:0]    ctrl_q;
   logic [ddrc_pkg::INV_W-1:0]     inv_q;
   logic [31:0]                    rdata_q;
   logic [31:0]                    stat;
   logic [ddrc_pkg::S_LEVEL_W-1:0] fifo_level;
   logic                           in_en;
   logic                           out_en;
   logic                           bidir;
   logic                           pre;
   logic                           clr_a;
   logic                           cell_rst;
   logic                           ce_in;
   logic                           ce_out;
   logic                           din;
   logic                           strobe_ok;
   logic                           cap_en;
   logic                           pop;
   logic                           nxt_hi;
   logic                           nxt_lo;
   logic                           oe_req;
   logic                           oe_vis;
   logic                           oe_neg_vis;
   logic                           phase;
   // cell storage holds value xor preset, so a clear to zero reads as the preset level
   logic                           in_rise_q;  // R1
   logic                           in_fall_q;
   logic                           hold_q;
   logic [1:0]                     pair_r_q;
   logic [1:0]                     pair_f_q;
   logic                           out_hi_q;
   logic                           out_lo_q;
   logic                           oe_q;
   logic                           oe_neg_q;

   ddrc_stream_if #(.W(ddrc_pkg::FIFO_W)) fill_if ();
   ddrc_stream_if #(.W(ddrc_pkg::FIFO_W)) drain_if ();

   // configuration registers
   always_ff @(posedge core_clk_i)
   begin
      if (!nrst_i)
         ctrl_q <= ddrc_pkg::CTRL_RST;
      else if (reg_we_i && reg_hit(reg_addr_i, ddrc_pkg::OFF_CTRL))
         ctrl_q <= reg_wdata_i[ddrc_pkg::CTRL_W-1:0];
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!nrst_i)
         inv_q <= ddrc_pkg::INV_RST;
      else if (reg_we_i && reg_hit(reg_addr_i, ddrc_pkg::OFF_INV))
         inv_q <= reg_wdata_i[ddrc_pkg::INV_W-1:0];
   end

   // mode decode; an illegal code turns the cell off
   always_comb
   begin
      in_en  = 1'b0;
      out_en = 1'b0;
      bidir  = 1'b0;
      unique case (ctrl_q[ddrc_pkg::C_MODE +: ddrc_pkg::C_MODE_W])
         ddrc_pkg::MODE_IN:
            in_en = 1'b1;
         ddrc_pkg::MODE_OUT:
            out_en = 1'b1;
         ddrc_pkg::MODE_BIDIR:
         begin
            in_en  = 1'b1;  // R9
            out_en = 1'b1;  // R9
            bidir  = 1'b1;
         end
         default:
            in_en = 1'b0;
      endcase
   end

   // control inputs, each pin input with its own inversion; the preset select has none
   assign pre      = ctrl_q[ddrc_pkg::C_PRESET];  // R16
   assign clr_a    = register_clear_preset_pin_i ^ inv_q[ddrc_pkg::I_CLR];  // R12
   assign cell_rst = ~nrst_i | (sclr_i ^ inv_q[ddrc_pkg::I_SCLR]);  // R17
   assign din      = pad_in_i ^ inv_q[ddrc_pkg::I_DIN];  // R12
   assign ce_in    = ctrl_q[ddrc_pkg::C_CE_IN] ? (ce_in_i ^ inv_q[ddrc_pkg::I_CE_IN])
                                               : 1'b1;  // R12
   assign ce_out   = ctrl_q[ddrc_pkg::C_CE_OUT] ? (ce_out_i ^ inv_q[ddrc_pkg::I_CE_OUT])
                                                : 1'b1;  // R11

   // strobe bus: data cells may gate their capture with it, strobe cells drive it
   assign strobe_ok    = (ctrl_q[ddrc_pkg::C_STROBE] && !ctrl_q[ddrc_pkg::C_ROLE_STB]
                          && !ctrl_q[ddrc_pkg::C_NO_SHIFT]) ? strobe_bus_i : 1'b1;  // R13 R14
   assign strobe_bus_o = ctrl_q[ddrc_pkg::C_ROLE_STB] & din;  // R13
   assign cap_en       = in_en & ce_in & strobe_ok;

   // input capture on both edges
   always_ff @(posedge core_clk_i or posedge clr_a)
   begin
      if (clr_a)
         in_rise_q <= 1'b0;
      else if (cell_rst)
         in_rise_q <= 1'b0;
      else if (cap_en)
         in_rise_q <= din ^ pre;  // R2
   end

   always_ff @(negedge core_clk_i or posedge clr_a)
   begin
      if (clr_a)
         in_fall_q <= 1'b0;
      else if (cell_rst)
         in_fall_q <= 1'b0;
      else if (cap_en)
         in_fall_q <= din ^ pre;  // R2
   end

   // transparent while the clock is high, closed while it is low
   always_latch
   begin
      if (clr_a)
         hold_q <= 1'b0;
      else if (core_clk_i)
         hold_q <= in_rise_q;  // R3
   end

   // rising alignment: {rise bit, following fall bit}
   always_ff @(posedge core_clk_i or posedge clr_a)
   begin
      if (clr_a)
         pair_r_q <= 2'h0;
      else if (cell_rst)
         pair_r_q <= 2'h0;
      else
         pair_r_q <= {hold_q, in_fall_q};  // R4
   end

   // falling alignment: {fall bit, following rise bit}
   always_ff @(negedge core_clk_i or posedge clr_a)
   begin
      if (clr_a)
         pair_f_q <= 2'h0;
      else if (cell_rst)
         pair_f_q <= 2'h0;
      else
         pair_f_q <= {in_fall_q, in_rise_q};  // R4
   end

   assign in_data_o = (ctrl_q[ddrc_pkg::C_ALIGN_F] ? pair_f_q : pair_r_q) ^ {2{pre}};  // R4

   // launch buffer in front of the output registers
   assign fill_if.valid  = out_valid_i;
   assign fill_if.data   = out_data_i;
   assign out_ready_o    = fill_if.ready;
   assign drain_if.ready = out_en & ce_out & ~cell_rst;
   assign pop            = drain_if.valid & drain_if.ready;
   assign nxt_hi         = drain_if.data[1] ^ inv_q[ddrc_pkg::I_DOUT] ^ pre;
   assign nxt_lo         = drain_if.data[0] ^ inv_q[ddrc_pkg::I_DOUT] ^ pre;

   ddrc_fifo #(.W(ddrc_pkg::FIFO_W), .DEPTH(ddrc_pkg::FIFO_DEPTH)) ddrc_fifo_inst
   (
      .core_clk_i (core_clk_i),
      .nrst_i     (nrst_i),
      .wr         (fill_if.snk),
      .rd         (drain_if.src),
      .level_o    (fifo_level)
   );

   // output registers load together on the rising edge, hold otherwise
   always_ff @(posedge core_clk_i or posedge clr_a)
   begin
      if (clr_a)
      begin
         out_hi_q <= 1'b0;
         out_lo_q <= 1'b0;
      end
      else if (cell_rst)
      begin
         out_hi_q <= 1'b0;
         out_lo_q <= 1'b0;
      end
      else if (pop)
      begin
         out_hi_q <= nxt_hi;  // R5 R11 R19
         out_lo_q <= nxt_lo;  // R5 R11 R19
      end
   end

   // clock-driven launch mux: high phase first bit, low phase second bit
   assign phase     = core_clk_i ^ inv_q[ddrc_pkg::I_CLK];  // R6 R12
   assign pad_out_o = out_en & ((phase ? out_hi_q : out_lo_q) ^ pre);  // R6 R7

   // enable registers share the output clock; only the rising-edge one also shares its clock enable
   assign oe_req = oe_i ^ inv_q[ddrc_pkg::I_OE] ^ ctrl_q[ddrc_pkg::C_OE_LOW];  // R8 R12

   always_ff @(posedge core_clk_i or posedge clr_a)
   begin
      if (clr_a)
         oe_q <= 1'b0;
      else if (cell_rst)
         oe_q <= 1'b0;
      else if (ce_out)
         oe_q <= (oe_req & out_en) ^ pre;  // R18
   end

   always_ff @(negedge core_clk_i or posedge clr_a)
   begin
      if (clr_a)
         oe_neg_q <= 1'b0;
      else if (cell_rst)
         oe_neg_q <= 1'b0;
      else
         oe_neg_q <= oe_q;  // R10
   end

   assign oe_vis     = oe_q ^ pre;
   assign oe_neg_vis = oe_neg_q ^ pre;
   assign pad_oe_o   = out_en & (bidir ? (oe_vis & oe_neg_vis) : oe_vis);  // R10

   // register read port
   always_comb
   begin
      stat = 32'h0000_0000;
      stat[ddrc_pkg::S_PAIR +: 2] = in_data_o;
      stat[ddrc_pkg::S_OE] = pad_oe_o;
      stat[ddrc_pkg::S_EMPTY] = ~drain_if.valid;
      stat[ddrc_pkg::S_FULL] = ~fill_if.ready;
      stat[ddrc_pkg::S_PAD] = din;
      stat[ddrc_pkg::S_LEVEL +: ddrc_pkg::S_LEVEL_W] = fifo_level;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!nrst_i)
         rdata_q <= 32'h0000_0000;
      else if (reg_re_i && reg_hit(reg_addr_i, ddrc_pkg::OFF_CTRL))
         rdata_q <= 32'(ctrl_q);
      else if (reg_re_i && reg_hit(reg_addr_i, ddrc_pkg::OFF_INV))
         rdata_q <= 32'(inv_q);
      else if (reg_re_i && reg_hit(reg_addr_i, ddrc_pkg::OFF_STAT))
         rdata_q <= stat;
      else
         rdata_q <= 32'h0000_0000;
   end

   assign reg_rdata_o = rdata_q;

   // checks
   AST_RATE: assert property (@(posedge core_clk_i) disable iff (!nrst_i)  // R15
      ddrc_pkg::CLK_PERIOD_NS >= ddrc_pkg::MIN_PERIOD_NS
      && ddrc_pkg::MAX_CLK_MHZ * ddrc_pkg::BITS_PER_CLK == ddrc_pkg::MAX_RATE_MBPS)
      else $error("clock faster than the rated ddr rate");

   AST_RISE_CAP: assert property (@(posedge core_clk_i) disable iff (!nrst_i || clr_a)  // R2
      (cap_en && !cell_rst) |=> (in_rise_q == ($past(din) ^ $past(pre))))
      else $error("rising capture missed the pin");

   AST_FALL_CAP: assert property (@(negedge core_clk_i) disable iff (!nrst_i || clr_a)  // R2
      (cap_en && !cell_rst) |=> (in_fall_q == ($past(din) ^ $past(pre))))
      else $error("falling capture missed the pin");

   AST_LATCH: assert property (@(posedge core_clk_i) disable iff (!nrst_i || clr_a)  // R3
      hold_q == in_rise_q)
      else $error("latch lost the high-time bit");

   AST_ALIGN: assert property (@(posedge core_clk_i) disable iff (!nrst_i || clr_a)  // R4
      (!$past(cell_rst) && !ctrl_q[ddrc_pkg::C_ALIGN_F])
      |-> (in_data_o == ({$past(hold_q), $past(in_fall_q)} ^ {2{pre}})))
      else $error("input pair not aligned to rising edge");

   AST_LOAD: assert property (@(posedge core_clk_i) disable iff (!nrst_i || clr_a)  // R5
      (pop && !cell_rst) |=> (out_hi_q == $past(nxt_hi) && out_lo_q == $past(nxt_lo)))
      else $error("output registers did not load the popped pair");

   AST_HOLD: assert property (@(posedge core_clk_i) disable iff (!nrst_i || clr_a)  // R11
      (!ce_out && !cell_rst) |=> ($stable(out_hi_q) && $stable(out_lo_q) && $stable(oe_q)))
      else $error("output registers moved with clock enable low");

   AST_PIN_HI: assert property (@(negedge core_clk_i) disable iff (!nrst_i || clr_a)  // R7
      (out_en && !inv_q[ddrc_pkg::I_CLK]) |-> (pad_out_o == (out_hi_q ^ pre)))
      else $error("pin not showing first bit in high phase");

   AST_PIN_LO: assert property (@(posedge core_clk_i) disable iff (!nrst_i || clr_a)  // R6
      (out_en && !inv_q[ddrc_pkg::I_CLK]) |-> (pad_out_o == (out_lo_q ^ pre)))
      else $error("pin not showing second bit in low phase");

   AST_OE_LATE: assert property (@(negedge core_clk_i) disable iff (!nrst_i || clr_a)  // R10
      (bidir && $rose(oe_vis) && $stable(pre)) |-> !pad_oe_o)
      else $error("bidirectional enable asserted before the falling edge");

   AST_STROBE: assert property (@(posedge core_clk_i) disable iff (!nrst_i)  // R13
      (ctrl_q[ddrc_pkg::C_ROLE_STB] ? (strobe_bus_o == din) : !strobe_bus_o)
      && (!ctrl_q[ddrc_pkg::C_ROLE_STB] || strobe_ok))
      else $error("strobe bus role violated");

   AST_NO_SHIFT: assert property (@(posedge core_clk_i) disable iff (!nrst_i || clr_a)  // R14
      (ctrl_q[ddrc_pkg::C_NO_SHIFT] && in_en && ce_in && !cell_rst)
      |=> (in_rise_q == ($past(din) ^ $past(pre))))
      else $error("read strobe not ignored without phase shifting");

   AST_SRST: assert property (@(posedge core_clk_i) disable iff (!nrst_i || clr_a)  // R17
      (cell_rst && !reg_we_i) |=> (out_hi_q == 1'b0 && oe_q == 1'b0 && in_rise_q == 1'b0))
      else $error("synchronous reset did not clear the cell");

   COV_BIDIR_OE: cover property (@(negedge core_clk_i) disable iff (!nrst_i)
      bidir && $rose(oe_vis));
   COV_POP: cover property (@(posedge core_clk_i) disable iff (!nrst_i) pop ##1 pop);
   COV_FULL: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
      out_valid_i && !out_ready_o);
   COV_FALL_ALIGN: cover property (@(negedge core_clk_i) disable iff (!nrst_i)
      in_en && cap_en && ctrl_q[ddrc_pkg::C_ALIGN_F]);
endmodule

`default_nettype wire

// ==== hw/ddrc_fifo.sv ====
// fifo: parameterised word buffer with registered read data
`timescale 1ns/1ps
`default_nettype none

module ddrc_fifo
#(
   parameter int unsigned W     = 2,
   parameter int unsigned DEPTH = 16
)
(
   input  wire logic                  core_clk_i,
   input  wire logic                  nrst_i,
   ddrc_stream_if.snk                 wr,
   ddrc_stream_if.src                 rd,
   output logic [$clog2(DEPTH):0]     level_o
);
   localparam int unsigned PW   = $clog2(DEPTH);
   localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

   logic [W-1:0]  mem_q [DEPTH];
   logic [PW-1:0] wr_ptr_q;
   logic [PW-1:0] rd_ptr_q;
   logic [PW:0]   cnt_q;
   logic          vld_q;
   logic [W-1:0]  data_q;
   logic          push;
   logic          load;

   // the output word counts toward the level, so the total never passes DEPTH
   assign level_o  = cnt_q + (PW+1)'(vld_q);
   assign push     = wr.valid & wr.ready;
   assign load     = (cnt_q != '0) & (~vld_q | rd.ready);
   assign wr.ready = (level_o != FULL);
   assign rd.valid = vld_q;
   assign rd.data  = data_q;

   always_ff @(posedge core_clk_i)
   begin
      if (push)
         mem_q[wr_ptr_q] <= wr.data;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!nrst_i)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         cnt_q    <= '0;
      end
      else
      begin
         wr_ptr_q <= wr_ptr_q + PW'(push);
         rd_ptr_q <= rd_ptr_q + PW'(load);
         cnt_q    <= cnt_q + (PW+1)'(push) - (PW+1)'(load);
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!nrst_i)
      begin
         vld_q  <= 1'b0;
         data_q <= '0;
      end
      else if (load)
      begin
         vld_q  <= 1'b1;
         data_q <= mem_q[rd_ptr_q];
      end
      else if (rd.ready)
         vld_q <= 1'b0;
   end

   AST_FIFO_HOLD: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      (vld_q && !rd.ready) |=> (vld_q && $stable(data_q)))
      else $error("fifo output changed while stalled");
   AST_FIFO_FULL: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      (wr.valid && !wr.ready && !rd.ready) |=> (level_o == FULL))
      else $error("fifo lost its fill level while stalled");
endmodule

`default_nettype wire

// ==== hw/ddrc_pkg.sv ====
// package: offsets, fields, reset values and rates of the ddr i/o register cell
package ddrc_pkg;
   localparam int unsigned AW            = 4;
   localparam int unsigned DW            = 32;
   localparam logic [3:0]  OFF_CTRL      = 4'h0;
   localparam logic [3:0]  OFF_INV       = 4'h4;
   localparam logic [3:0]  OFF_STAT      = 4'h8;
   // control register fields
   localparam int unsigned C_MODE        = 0;
   localparam int unsigned C_MODE_W      = 3;
   localparam int unsigned C_ALIGN_F     = 3;
   localparam int unsigned C_OE_LOW      = 4;
   localparam int unsigned C_PRESET      = 5;
   localparam int unsigned C_STROBE      = 6;
   localparam int unsigned C_NO_SHIFT    = 7;
   localparam int unsigned C_ROLE_STB    = 8;
   localparam int unsigned C_CE_IN       = 9;
   localparam int unsigned C_CE_OUT      = 10;
   localparam int unsigned CTRL_W        = 11;
   localparam logic [10:0] CTRL_RST      = 11'h000;
   // inversion register fields
   localparam int unsigned I_CLK         = 0;
   localparam int unsigned I_CE_IN       = 1;
   localparam int unsigned I_CE_OUT      = 2;
   localparam int unsigned I_CLR         = 3;
   localparam int unsigned I_SCLR        = 4;
   localparam int unsigned I_DIN         = 5;
   localparam int unsigned I_DOUT        = 6;
   localparam int unsigned I_OE          = 7;
   localparam int unsigned INV_W         = 8;
   localparam logic [7:0]  INV_RST       = 8'h00;
   // status register fields
   localparam int unsigned S_PAIR        = 0;
   localparam int unsigned S_OE          = 2;
   localparam int unsigned S_EMPTY       = 3;
   localparam int unsigned S_FULL        = 4;
   localparam int unsigned S_PAD         = 5;
   localparam int unsigned S_LEVEL       = 8;
   localparam int unsigned S_LEVEL_W     = 5;
   // launch buffer
   localparam int unsigned FIFO_W        = 2;
   localparam int unsigned FIFO_DEPTH    = 16;
   // rates
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned MAX_CLK_MHZ   = 200;
   localparam int unsigned MIN_PERIOD_NS = 1000 / MAX_CLK_MHZ;
   localparam int unsigned BITS_PER_CLK  = 2;
   localparam int unsigned MAX_RATE_MBPS = 400;
   typedef enum logic [2:0] {
      MODE_IN    = 3'h1,
      MODE_OUT   = 3'h2,
      MODE_BIDIR = 3'h4
   } ddrc_mode_t;
endpackage

// ==== hw/ddrc_stream_if.sv ====
// interface: valid/ready word stream between the cell and its launch buffer
`timescale 1ns/1ps
`default_nettype none

interface ddrc_stream_if
#(
   parameter int unsigned W = 2
);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire
